/* File: design/ssp_link_if.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ssp_params.svh"

interface ssp_link_if;
    logic [`SSP_WORD_W-1:0] word;

    modport rx   (output word);
    modport core (input  word);
endinterface : ssp_link_if

`default_nettype wire

/* File: design/ssp_params.svh */
`ifndef SSP_PARAMS_SVH
`define SSP_PARAMS_SVH

// serial word
`define SSP_WORD_W          21
`define SSP_C1_POS          0
`define SSP_C2_POS          1
`define SSP_LATCH_LSB       2
`define SSP_LATCH_W         19
`define SSP_FUNC_W          18

// destination codes, written as {c1, c2}
`define SSP_DEST_REF        2'b00
`define SSP_DEST_FB         2'b10
`define SSP_DEST_FUNC       2'b01
`define SSP_DEST_INIT       2'b11

// reference latch fields
`define SSP_REF_RATIO_LSB   0
`define SSP_REF_RATIO_W     14
`define SSP_REF_TEST_LSB    14
`define SSP_REF_TEST_W      4
`define SSP_REF_PREC_POS    18

// feedback latch fields
`define SSP_SWALLOW_LSB     0
`define SSP_SWALLOW_W       5
`define SSP_PROG_LSB        5
`define SSP_PROG_W          13
`define SSP_GAIN_POS        18

// reset values
`define SSP_REF_RESET       19'h00000
`define SSP_FB_RESET        19'h00000
`define SSP_FUNC_RESET      18'h00000

// output-select codes, written as {f3, f4, f5}
`define SSP_MUX_HIZ         3'h0
`define SSP_MUX_REF         3'h1
`define SSP_MUX_FB          3'h2
`define SSP_MUX_SDO         3'h3
`define SSP_MUX_LOCK        3'h4
`define SSP_MUX_LOCK_OD     3'h5
`define SSP_MUX_HIGH        3'h6
`define SSP_MUX_LOW         3'h7

// acquisition timeout: terminal count = (value + 1) << shift
`define SSP_TIMEOUT_SHIFT   2
`define SSP_TIMEOUT_CNT_W   7
`define SSP_QUARTER_SHIFT   2

// pin synchroniser slots
`define SSP_PIN_LE          0
`define SSP_PIN_CE          1
`define SSP_PIN_SDO         2
`define SSP_PIN_N           3
`define SSP_SYNC_DEPTH      3

`endif

/* File: design/ssp_pkg.sv */
package ssp_pkg;

    // function latch as stored, field 1 at bit 0
    typedef struct packed {
        logic       powerdown_sync_bit;
        logic [2:0] func_test_bits;
        logic [3:0] timeout_value;
        logic       timeout_enable_bit;
        logic       acquire_control_bit;
        logic       acquire_enable_bit;
        logic       pump_hiz_bit;
        logic       detector_polarity_bit;
        logic [2:0] mux_raw;
        logic       powerdown_bit;
        logic       counter_reset_bit;
    } ssp_func_t;

    typedef enum logic [1:0] {
        SSP_PD_UP,
        SSP_PD_ARMED,
        SSP_PD_DOWN
    } ssp_pd_state_t;

endpackage : ssp_pkg

/* File: design/ssp_shift_rx.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ssp_params.svh"

module ssp_shift_rx
    import ssp_pkg::*;
(
    input  wire logic     link_clk,
    input  wire logic     rst_n,
    input  wire logic     ser_data,
    ssp_link_if.rx        link
);

    logic [`SSP_WORD_W-1:0] shift_q;
    logic [`SSP_WORD_W-1:0] shift_d;

    // msb first: each new bit enters at bit 0 and pushes older ones up
    always_comb
    begin
        shift_d = {shift_q[`SSP_WORD_W-2:0], ser_data};
    end

    // reset only asserts here; the link clock stands still at release
    always_ff @(posedge link_clk or negedge rst_n)
    begin
        if (!rst_n)
            shift_q <= '0;
        else
            shift_q <= shift_d;
    end

    assign link.word = shift_q;

endmodule : ssp_shift_rx

`default_nettype wire

/* File: design/ssp_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ssp_params.svh"

module ssp_top
    import ssp_pkg::*;
#(
    parameter int PRESCALE_MOD = 32
)
(
    input  wire logic                     clk,
    input  wire logic                     arst_n,
    input  wire logic                     link_clk,
    input  wire logic                     ser_data,
    input  wire logic                     load_strobe,
    input  wire logic                     chip_enable,
    input  wire logic                     prescaler_tick,
    input  wire logic                     lock_detect_in,
    output logic [`SSP_LATCH_W-1:0]       reference_divider_latch,
    output logic [`SSP_LATCH_W-1:0]       feedback_divider_latch,
    output logic [`SSP_FUNC_W-1:0]        function_control_latch,
    output logic                          ref_pulse,
    output logic                          fb_pulse,
    output logic                          modulus_ctl,
    output logic                          mux_freq_lock_out,
    output logic                          mux_freq_lock_oe_n,
    output logic                          detector_polarity,
    output logic                          pump_hiz,
    output logic                          pump_current_hi,
    output logic                          aux_gain_out,
    output logic                          divide_quarter,
    output logic                          powered_down
);

    if (PRESCALE_MOD != 8 && PRESCALE_MOD != 32)
    begin : g_bad_modulus
        $error("ssp_top: PRESCALE_MOD must be 8 or 32");
    end

    ////////////////////////////////////////////////////////////////////////
    // reset release and serial receiver

    logic [1:0] rst_pipe_q;
    logic       rst_n;

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            rst_pipe_q <= 2'b00;
        else
            rst_pipe_q <= {rst_pipe_q[0], 1'b1};
    end

    assign rst_n = rst_pipe_q[1];

    ssp_link_if link ();

    ssp_shift_rx u_rx (
        .link_clk (link_clk),
        .rst_n    (rst_n),
        .ser_data (ser_data),
        .link     (link.rx)
    );

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers: a change counts once stages two and three agree

    logic [`SSP_PIN_N-1:0] pin_in;
    logic [`SSP_PIN_N-1:0] lvl_q;
    logic [`SSP_PIN_N-1:0] lvl_d;

    assign pin_in = {link.word[`SSP_WORD_W-1], chip_enable, load_strobe};

    for (genvar i = 0; i < `SSP_PIN_N; i++)
    begin : g_sync
        logic [`SSP_SYNC_DEPTH-1:0] stage_q;

        always_ff @(posedge clk or negedge rst_n)
        begin
            if (!rst_n)
                stage_q <= '0;
            else
                stage_q <= {stage_q[`SSP_SYNC_DEPTH-2:0], pin_in[i]};
        end

        always_comb
        begin
            if (stage_q[1] == stage_q[2])
                lvl_d[i] = stage_q[2];
            else
                lvl_d[i] = lvl_q[i];
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            lvl_q <= '0;
        else
            lvl_q <= lvl_d;
    end

    ////////////////////////////////////////////////////////////////////////
    // helpers

    // modulus-8 parts ignore the top two swallow bits
    function automatic logic [`SSP_SWALLOW_W-1:0] swallow_mask(
        input logic [`SSP_SWALLOW_W-1:0] a
    );
        if (PRESCALE_MOD == 8)
            swallow_mask = {2'b00, a[2:0]};
        else
            swallow_mask = a;
    endfunction : swallow_mask

    // returns {pin level, output enable low}
    function automatic logic [1:0] mux_drive(
        input logic [2:0] sel,
        input logic       refp,
        input logic       fbp,
        input logic       sdo,
        input logic       lock
    );
        case (sel)
            `SSP_MUX_HIZ:     mux_drive = 2'b01;
            `SSP_MUX_REF:     mux_drive = {refp, 1'b0};
            `SSP_MUX_FB:      mux_drive = {fbp, 1'b0};
            `SSP_MUX_SDO:     mux_drive = {sdo, 1'b0};
            `SSP_MUX_LOCK:    mux_drive = {lock, 1'b0};
            // open drain: sink only while unlocked
            `SSP_MUX_LOCK_OD: mux_drive = {1'b0, lock};
            `SSP_MUX_HIGH:    mux_drive = 2'b10;
            default:          mux_drive = 2'b00;
        endcase
    endfunction : mux_drive

    ////////////////////////////////////////////////////////////////////////
    // latch transfer

    logic [`SSP_LATCH_W-1:0] ref_q, ref_d;
    logic [`SSP_LATCH_W-1:0] fb_q,  fb_d;
    ssp_func_t               fn_q,  fn_d;
    logic                    le_rise;
    logic [1:0]              dest;
    logic                    timeout_done_q;
    logic                    gain_q;

    assign gain_q = fb_q[`SSP_GAIN_POS];

    always_comb
    begin
        // the word is quiet: the host stops the link clock around the strobe
        le_rise = lvl_d[`SSP_PIN_LE] & ~lvl_q[`SSP_PIN_LE];
        dest    = {link.word[`SSP_C1_POS], link.word[`SSP_C2_POS]};
        ref_d   = ref_q;
        fb_d    = fb_q;
        fn_d    = fn_q;
        if (timeout_done_q)
            fb_d[`SSP_GAIN_POS] = 1'b0;
        if (le_rise)
        begin
            case (dest)
                `SSP_DEST_REF:
                    ref_d = link.word[`SSP_LATCH_LSB+:`SSP_LATCH_W];
                `SSP_DEST_FB:
                    fb_d = link.word[`SSP_LATCH_LSB+:`SSP_LATCH_W];
                `SSP_DEST_FUNC,
                `SSP_DEST_INIT:
                    fn_d = link.word[`SSP_LATCH_LSB+:`SSP_FUNC_W];
                default:
                    ref_d = ref_q;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ref_q <= `SSP_REF_RESET;
            fb_q  <= `SSP_FB_RESET;
            fn_q  <= `SSP_FUNC_RESET;
        end
        else
        begin
            ref_q <= ref_d;
            fb_q  <= fb_d;
            fn_q  <= fn_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // divider chain and timeout counter

    logic [`SSP_REF_RATIO_W-1:0]  r_val;
    logic [`SSP_PROG_W-1:0]       b_eff;
    logic [`SSP_SWALLOW_W-1:0]    a_eff;
    logic [`SSP_REF_RATIO_W-1:0]  rcnt_q, rcnt_d;
    logic [`SSP_PROG_W-1:0]       bcnt_q, bcnt_d;
    logic [`SSP_SWALLOW_W-1:0]    arem_q, arem_d;
    logic [`SSP_TIMEOUT_CNT_W-1:0] tcnt_q, tcnt_d;
    logic [`SSP_TIMEOUT_CNT_W-1:0] t_term;
    logic                         refp_d, fbp_d, modc_d, tdone_d;
    logic                         hold;
    logic                         acq_active;
    logic                         pd_active;

    always_comb
    begin
        r_val = ref_q[`SSP_REF_RATIO_LSB+:`SSP_REF_RATIO_W];
        b_eff = fb_q[`SSP_PROG_LSB+:`SSP_PROG_W];
        a_eff = swallow_mask(fb_q[`SSP_SWALLOW_LSB+:`SSP_SWALLOW_W]);
        // quarter mode scales both counters down for acquisition
        if (divide_quarter)
        begin
            b_eff = b_eff >> `SSP_QUARTER_SHIFT;
            a_eff = a_eff >> `SSP_QUARTER_SHIFT;
        end
        hold   = fn_q.counter_reset_bit | pd_active;
        rcnt_d = rcnt_q;
        bcnt_d = bcnt_q;
        arem_d = arem_q;
        refp_d = 1'b0;
        fbp_d  = 1'b0;
        // both counters leave hold on the same edge, so they start aligned
        if (hold)
        begin
            rcnt_d = '0;
            bcnt_d = '0;
            arem_d = a_eff;
        end
        else
        begin
            if (rcnt_q >= r_val - `SSP_REF_RATIO_W'(1))
            begin
                rcnt_d = '0;
                refp_d = 1'b1;
            end
            else
                rcnt_d = rcnt_q + `SSP_REF_RATIO_W'(1);
            // swallow first a_eff ticks at P+1, the rest at P: total P*B+A
            if (prescaler_tick)
            begin
                if (bcnt_q >= b_eff - `SSP_PROG_W'(1))
                begin
                    bcnt_d = '0;
                    fbp_d  = 1'b1;
                    arem_d = a_eff;
                end
                else
                begin
                    bcnt_d = bcnt_q + `SSP_PROG_W'(1);
                    if (arem_q != '0)
                        arem_d = arem_q - `SSP_SWALLOW_W'(1);
                end
            end
        end
        modc_d = (arem_d != '0);
        // timeout runs in reference cycles while acquisition is active
        t_term  = `SSP_TIMEOUT_CNT_W'(({3'b000, fn_q.timeout_value}
                  + 7'h01) << `SSP_TIMEOUT_SHIFT);
        tdone_d = 1'b0;
        tcnt_d  = tcnt_q;
        if (hold || !acq_active || !fn_q.timeout_enable_bit)
            tcnt_d = '0;
        else if (ref_pulse)
        begin
            if (tcnt_q >= t_term - `SSP_TIMEOUT_CNT_W'(1))
            begin
                tcnt_d  = '0;
                tdone_d = 1'b1;
            end
            else
                tcnt_d = tcnt_q + `SSP_TIMEOUT_CNT_W'(1);
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rcnt_q         <= '0;
            bcnt_q         <= '0;
            arem_q         <= '0;
            tcnt_q         <= '0;
            ref_pulse      <= 1'b0;
            fb_pulse       <= 1'b0;
            modulus_ctl    <= 1'b0;
            timeout_done_q <= 1'b0;
        end
        else
        begin
            rcnt_q         <= rcnt_d;
            bcnt_q         <= bcnt_d;
            arem_q         <= arem_d;
            tcnt_q         <= tcnt_d;
            ref_pulse      <= refp_d;
            fb_pulse       <= fbp_d;
            modulus_ctl    <= modc_d;
            timeout_done_q <= tdone_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // powerdown

    ssp_pd_state_t pd_q, pd_d;
    logic          ce_low;

    assign pd_active = (pd_q == SSP_PD_DOWN);

    always_comb
    begin
        ce_low = ~lvl_q[`SSP_PIN_CE];
        pd_d   = pd_q;
        case (pd_q)
            SSP_PD_UP:
                if (ce_low)
                    pd_d = SSP_PD_DOWN;
                else if (fn_q.powerdown_bit && fn_q.powerdown_sync_bit)
                    pd_d = SSP_PD_ARMED;
                else if (fn_q.powerdown_bit)
                    pd_d = SSP_PD_DOWN;
            // synchronous mode waits for a pump event to avoid a jump
            SSP_PD_ARMED:
                if (ce_low || ref_pulse)
                    pd_d = SSP_PD_DOWN;
                else if (!fn_q.powerdown_bit)
                    pd_d = SSP_PD_UP;
            SSP_PD_DOWN:
                if (!ce_low && !fn_q.powerdown_bit)
                    pd_d = SSP_PD_UP;
            default:
                pd_d = SSP_PD_UP;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            pd_q <= SSP_PD_DOWN;
        else
            pd_q <= pd_d;
    end

    ////////////////////////////////////////////////////////////////////////
    // decoded outputs

    logic [2:0] mux_sel;
    logic [1:0] mux_d;
    logic       hiz_d, cur_d, aux_d, quart_d;

    always_comb
    begin
        acq_active = fn_q.acquire_enable_bit & gain_q;
        mux_sel = {fn_q.mux_raw[0], fn_q.mux_raw[1], fn_q.mux_raw[2]};
        mux_d   = mux_drive(mux_sel, ref_pulse, fb_pulse,
                            lvl_q[`SSP_PIN_SDO], lock_detect_in);
        hiz_d   = fn_q.pump_hiz_bit | pd_active;
        cur_d   = gain_q;
        if (fn_q.acquire_enable_bit)
            aux_d = acq_active;
        else
            aux_d = fn_q.acquire_control_bit;
        quart_d = acq_active & fn_q.acquire_control_bit;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mux_freq_lock_out  <= 1'b0;
            mux_freq_lock_oe_n <= 1'b1;
            detector_polarity  <= 1'b0;
            pump_hiz           <= 1'b1;
            pump_current_hi    <= 1'b0;
            aux_gain_out       <= 1'b0;
            divide_quarter     <= 1'b0;
            powered_down       <= 1'b1;
        end
        else
        begin
            mux_freq_lock_out  <= mux_d[1];
            mux_freq_lock_oe_n <= mux_d[0];
            detector_polarity  <= fn_q.detector_polarity_bit;
            pump_hiz           <= hiz_d;
            pump_current_hi    <= cur_d;
            aux_gain_out       <= aux_d;
            divide_quarter     <= quart_d;
            powered_down       <= pd_active;
        end
    end

    assign reference_divider_latch = ref_q;
    assign feedback_divider_latch  = fb_q;
    assign function_control_latch  = fn_q;

endmodule : ssp_top

`default_nettype wire

/* File: dv/ssp_host_model.sv */
`timescale 1ns/1ps
`default_nettype none

module ssp_host_model
(
    output var logic link_clk,
    output var logic ser_data,
    output var logic load_strobe
);
    initial
    begin
        link_clk    = 1'b0;
        ser_data    = 1'b1;
        load_strobe = 1'b0;
    end

    // shift clock runs only inside a frame, idle low
    task automatic send_word(input logic [20:0] w);
        for (int i = 20; i >= 0; i--)
        begin
            ser_data = w[i];
            #40 link_clk = 1'b1;
            #40 link_clk = 1'b0;
        end
        // released data line must not keep showing the last bit
        ser_data = ~w[0];
        #50 load_strobe = 1'b1;
        #100 load_strobe = 1'b0;
        // quiet link until the strobe has crossed into the core clock
        #100;
    endtask : send_word
endmodule : ssp_host_model

`default_nettype wire

/* File: dv/ssp_top_properties.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ssp_params.svh"

module ssp_top_properties
(
    input wire logic                    clk,
    input wire logic                    arst_n,
    input wire logic                    load_strobe,
    input wire logic                    chip_enable,
    input wire logic [`SSP_LATCH_W-1:0] reference_divider_latch,
    input wire logic [`SSP_LATCH_W-1:0] feedback_divider_latch,
    input wire logic [`SSP_FUNC_W-1:0]  function_control_latch,
    input wire logic                    ref_pulse,
    input wire logic                    fb_pulse,
    input wire logic                    mux_freq_lock_out,
    input wire logic                    mux_freq_lock_oe_n,
    input wire logic                    detector_polarity,
    input wire logic                    pump_hiz,
    input wire logic                    pump_current_hi,
    input wire logic                    aux_gain_out,
    input wire logic                    powered_down
);
    logic [`SSP_FUNC_W-1:0] f;
    assign f = function_control_latch;

    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);

    a_pump_hiz: assert property (f[6] [*2] |-> pump_hiz)
        else $error("pump not released to high impedance");
    a_polarity_follows: assert property ($stable(f[5]) [*2] |->
        detector_polarity == f[5]) else $error("detector polarity wrong");
    a_aux_direct: assert property ((!f[7] && $stable(f)) [*2] |->
        aux_gain_out == f[8]) else $error("aux output not the bit");
    a_pump_current: assert property ($stable(feedback_divider_latch[18])
        [*2] |-> pump_current_hi == feedback_divider_latch[18])
        else $error("pump current not the gain bit");
    a_mux_const: assert property (($stable(f) && f[2] && f[3]) [*3]
        |-> !mux_freq_lock_oe_n && mux_freq_lock_out == !f[4])
        else $error("constant mux level wrong");
    a_mux_release: assert property (($stable(f) && f[4:2] == 3'h0) [*3]
        |-> mux_freq_lock_oe_n) else $error("mux pin not released");
    a_latch_hold: assert property (!load_strobe [*8] |->
        $stable(reference_divider_latch) && $stable(f)
        && $stable(feedback_divider_latch[17:0]))
        else $error("latch changed without strobe");
    a_ref_period: assert property (ref_pulse && !f[0] && !powered_down
        && reference_divider_latch[13:0] == 14'h0003 |=> !ref_pulse ##1
        !ref_pulse ##1 (ref_pulse || f[0] || powered_down))
        else $error("reference period not three");
    a_reset_holds: assert property (f[0] [*3] |-> !ref_pulse && !fb_pulse)
        else $error("counter pulse while held");
    a_ce_down: assert property (!chip_enable [*8] |-> powered_down
        && pump_hiz) else $error("chip enable low but powered");
endmodule : ssp_top_properties

bind ssp_top ssp_top_properties i_props
(
    .clk, .arst_n, .load_strobe, .chip_enable, .reference_divider_latch,
    .feedback_divider_latch, .function_control_latch, .ref_pulse, .fb_pulse,
    .mux_freq_lock_out, .mux_freq_lock_oe_n, .detector_polarity, .pump_hiz,
    .pump_current_hi, .aux_gain_out, .powered_down
);

`default_nettype wire

/* File: dv/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ssp_params.svh"

`define CHK(a, b) \
    begin \
        checked++; \
        if ((a) !== (b)) \
        begin \
            bad_count++; \
            $display("ERROR t=%0t got %h exp %h", $time, (a), (b)); \
        end \
    end

module testbench;
    logic clk, arst_n, link_clk, ser_data, load_strobe, chip_enable;
    logic prescaler_tick, lock_detect_in, ref_pulse, fb_pulse;
    logic mux_freq_lock_out, mux_freq_lock_oe_n, detector_polarity;
    logic pump_hiz, pump_current_hi, aux_gain_out, powered_down;
    logic modulus_ctl, divide_quarter;
    logic [`SSP_LATCH_W-1:0] reference_divider_latch, feedback_divider_latch;
    logic [`SSP_FUNC_W-1:0]  function_control_latch;
    int                      bad_count = 0;
    int                      checked   = 0;
    int                      cycles    = 0;

    ssp_top #(.PRESCALE_MOD(32)) i_dut
    (
        .clk, .arst_n, .link_clk, .ser_data, .load_strobe, .chip_enable,
        .prescaler_tick, .lock_detect_in, .reference_divider_latch,
        .feedback_divider_latch, .function_control_latch, .ref_pulse,
        .fb_pulse, .modulus_ctl, .mux_freq_lock_out, .mux_freq_lock_oe_n,
        .detector_polarity, .pump_hiz, .pump_current_hi, .aux_gain_out,
        .divide_quarter, .powered_down
    );
    ssp_host_model i_host (.link_clk, .ser_data, .load_strobe);

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // one prescaler output every second core cycle
    always @(posedge clk)
    begin
        #1;
        prescaler_tick = arst_n & ~prescaler_tick;
        cycles++;
        if (cycles == 12000)
        begin
            bad_count++;
            test_done;
        end
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc

    task automatic snd(input logic [20:0] w);
        i_host.send_word(w);
        cyc(8);
    endtask : snd

    // cycles between two pulses of the chosen divider
    task automatic gap(input bit fb, output int n);
        n = 0;
        while ((fb ? fb_pulse : ref_pulse) !== 1'b1 && n < 200)
        begin
            cyc(1);
            n++;
        end
        n = 0;
        do
        begin
            cyc(1);
            n++;
        end while ((fb ? fb_pulse : ref_pulse) !== 1'b1 && n < 200);
    endtask : gap

    task test_done;
        $display("checked %0d bad_count %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : test_done

    ////////////////////////////////////////////////////////////////////////
    task automatic t_div;
        int n;
        int m;
        snd({1'b1, 4'h0, 14'h0003, 2'b00});
        `CHK(reference_divider_latch, 19'h40003)
        `CHK(feedback_divider_latch, 19'h00000)
        gap(0, n);
        `CHK(n, 3)
        snd({1'b1, 13'd31, 5'd5, 2'b01});
        `CHK(feedback_divider_latch, {1'b1, 13'd31, 5'd5})
        `CHK(pump_current_hi, 1'b1)
        gap(1, n);
        `CHK(n, 31 * 2)
        // swallow phase: five ticks, two cycles apart, in every period
        m = 0;
        repeat (62)
        begin
            cyc(1);
            if (modulus_ctl === 1'b1)
                m++;
        end
        `CHK(m, 5 * 2)
        snd({1'b0, 13'd31, 5'd5, 2'b01});
        `CHK(pump_current_hi, 1'b0)
        $display("divider test done");
    endtask : t_div

    task automatic t_func;
        logic [17:0] f;
        for (int c = 0; c < 8; c++)
        begin
            f = 18'h0;
            f[4:2] = {c[0], c[1], c[2]};
            f[5] = c[0];
            f[6] = c[1];
            f[8] = c[2];
            lock_detect_in = c[1] ^ c[0];
            snd({1'b1, f, (c[0] ? 2'b11 : 2'b10)});
            `CHK(function_control_latch, f)
            `CHK(detector_polarity, f[5])
            `CHK(pump_hiz, f[6])
            `CHK(aux_gain_out, f[8])
            `CHK(mux_freq_lock_oe_n, (c == 0 || c == 5))
            if (c > 2)
                `CHK(mux_freq_lock_out, 8'h48 >> c & 1'b1)
        end
        snd({1'b0, 18'h0, 2'b10});
        $display("function test done");
    endtask : t_func

    task automatic t_hold;
        int n;
        int seen;
        snd({1'b0, 18'h00001, 2'b10});
        seen = 0;
        repeat (40)
        begin
            cyc(1);
            if (ref_pulse !== 1'b0 || fb_pulse !== 1'b0)
                seen++;
        end
        `CHK(seen, 0)
        snd({1'b0, 18'h0, 2'b10});
        gap(0, n);
        `CHK(n, 3)
        chip_enable = 1'b0;
        cyc(8);
        `CHK({powered_down, pump_hiz}, 2'b11)
        chip_enable = 1'b1;
        cyc(8);
        `CHK(powered_down, 1'b0)
        snd({1'b0, 18'h00002, 2'b10});
        `CHK(powered_down, 1'b1)
        snd({1'b0, 18'h0, 2'b10});
        `CHK(powered_down, 1'b0)
        snd({1'b0, 18'h20002, 2'b11});
        `CHK(powered_down, 1'b1)
        snd({1'b0, 18'h0, 2'b10});
        $display("hold and powerdown test done");
    endtask : t_hold

    task automatic t_tmo;
        int n;
        snd({1'b0, 18'h00f80, 2'b10});
        `CHK(aux_gain_out, 1'b0)
        `CHK(divide_quarter, 1'b0)
        snd({1'b1, 13'd31, 5'd5, 2'b01});
        `CHK(aux_gain_out, 1'b1)
        `CHK(divide_quarter, 1'b1)
        n = 0;
        while (feedback_divider_latch[18] !== 1'b0 && n < 200)
        begin
            cyc(1);
            n++;
        end
        `CHK(feedback_divider_latch, {1'b0, 13'd31, 5'd5})
        `CHK(n > 25 && n < 50, 1'b1)
        snd({1'b0, 18'h0, 2'b10});
        $display("timeout test done");
    endtask : t_tmo

    initial
    begin
        arst_n         = 1'b0;
        chip_enable    = 1'b1;
        lock_detect_in = 1'b1;
        repeat (10) @(posedge clk);
        #1 arst_n = 1'b1;
        cyc(10);
        t_div;
        t_func;
        t_hold;
        t_tmo;
        test_done;
    end
endmodule : testbench

`default_nettype wire
